// file: test_ubf_core.sv
// Self-checking bench for the break field and baud unit.
`timescale 1ns/100ps
`default_nettype none
module test_ubf_core;
	import ubf_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	ubf_cfg_t i_cfg = '0;
	logic i_break_tx_set = 1'b0;
	logic i_break_rx_set = 1'b0;
	logic i_err_status_rd = 1'b0;
	logic i_tx_wr = 1'b0;
	logic [7:0] i_tx_data = 8'h00;
	logic i_rx_ready = 1'b0;
	logic i_serial_rx_pin;
	logic o_tx_buf_full, o_tx_busy, o_rx_valid, o_serial_tx_pin;
	logic o_break_tx_trigger, o_break_rx_enable, o_break_rx_flag;
	logic o_overrun_flag, o_parity_err_flag, o_framing_err_flag;
	logic o_tx_done_irq, o_rx_done_irq, o_rx_err_irq, o_base_clk;
	ubf_rx_word_t o_rx_word;
	int num_errors = 0;
	int comparisons = 0;
	int n_txd = 0;
	int n_rxd = 0;
	int n_rxe = 0;
	logic [7:0] got;
	logic ok;
	ubf_core ubf_core_i (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_cfg(i_cfg),
		.i_break_tx_set(i_break_tx_set),
		.i_break_rx_set(i_break_rx_set),
		.i_err_status_rd(i_err_status_rd),
		.i_tx_wr(i_tx_wr),
		.i_tx_data(i_tx_data),
		.o_tx_buf_full(o_tx_buf_full),
		.o_tx_busy(o_tx_busy),
		.o_rx_valid(o_rx_valid),
		.i_rx_ready(i_rx_ready),
		.o_rx_word(o_rx_word),
		.i_serial_rx_pin(i_serial_rx_pin),
		.o_serial_tx_pin(o_serial_tx_pin),
		.o_break_tx_trigger(o_break_tx_trigger),
		.o_break_rx_enable(o_break_rx_enable),
		.o_break_rx_flag(o_break_rx_flag),
		.o_overrun_flag(o_overrun_flag),
		.o_parity_err_flag(o_parity_err_flag),
		.o_framing_err_flag(o_framing_err_flag),
		.o_tx_done_irq(o_tx_done_irq),
		.o_rx_done_irq(o_rx_done_irq),
		.o_rx_err_irq(o_rx_err_irq),
		.o_base_clk(o_base_clk)
	);
	ubf_node ubf_node_i (.i_clk(i_clk), .i_tx_line(o_serial_tx_pin),
		.o_line(i_serial_rx_pin));
	// Clock and interrupt pulse counters.
	always #5 i_clk = ~i_clk;
	always @(negedge i_clk) begin
		n_txd += int'(o_tx_done_irq);
		n_rxd += int'(o_rx_done_irq);
		n_rxe += int'(o_rx_err_irq);
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic ticks(output int n);
		n = 0;
		for (int c = 0; c < 64; c++) begin
			cyc(1);
			n += int'(o_base_clk);
		end
	endtask
	// Power gating and base clock select.
	task automatic t_clock;
		int n;
		ticks(n);
		chk(n, 0);
		chk(o_serial_tx_pin, 0);
		i_cfg.pwr = 1'b1;
		cyc(1);
		chk(o_serial_tx_pin, 1);
		for (int s = 0; s < 6; s++) begin
			i_cfg.clk_sel = (s == 5) ? 4'hB : 4'(s);
			cyc(20);
			ticks(n);
			chk(n, (s == 5) ? 0 : 64 >> s);
		end
		i_cfg.clk_sel = 4'h0;
		$display("clock test done");
	endtask
	// Break fields of every length.
	task automatic t_brk_tx;
		int low;
		int d;
		i_cfg.tx_en = 1'b1;
		cyc(1);
		for (int len = 0; len < 8; len++) begin
			i_cfg.brk_len = 3'(len);
			d = n_txd;
			i_break_tx_set = 1'b1;
			cyc(1);
			i_break_tx_set = 1'b0;
			low = 0;
			for (int w = 0; w < 400 && o_serial_tx_pin; w++)
				cyc(1);
			for (int w = 0; w < 400 && !o_serial_tx_pin; w++) begin
				cyc(1);
				low++;
			end
			chk((low + 8) / 16, 13 + len);
			cyc(2);
			chk(n_txd - d, 1);
			chk(o_break_tx_trigger, 0);
			cyc(40);
			chk(o_tx_busy, 0);
		end
		$display("break transmit test done");
	endtask
	// One byte out, then four in with a stalled reader.
	task automatic t_bytes;
		int d;
		int e;
		i_tx_data = 8'hA5;
		i_tx_wr = 1'b1;
		cyc(1);
		i_tx_wr = 1'b0;
		ubf_node_i.get_frame(got, ok);
		chk({ok, got}, 9'h1A5);
		cyc(1);
		i_cfg.rx_en = 1'b1;
		cyc(4);
		d = n_rxd;
		e = n_rxe;
		ubf_node_i.send_frame(8'h3C, 1'b1);
		chk(n_rxd - d, 1);
		ubf_node_i.send_frame(8'h5A, 1'b0);
		chk(n_rxe - e, 1);
		chk(o_framing_err_flag, 1);
		cyc(1);
		i_cfg.merge = 1'b1;
		ubf_node_i.send_frame(8'h77, 1'b1);
		chk(n_rxd - d, 2);
		chk(n_rxe - e, 1);
		chk(o_overrun_flag, 1);
		cyc(1);
		i_err_status_rd = 1'b1;
		cyc(1);
		i_err_status_rd = 1'b0;
		cyc(1);
		chk({o_overrun_flag, o_framing_err_flag}, 0);
		chk(o_rx_word, {8'h3C, 2'b00});
		i_rx_ready = 1'b1;
		cyc(1);
		chk({o_rx_valid, o_rx_word}, {1'b1, 8'h5A, 2'b01});
		cyc(1);
		i_rx_ready = 1'b0;
		chk(o_rx_valid, 0);
		// Even parity option: a wrong parity bit is flagged and kept.
		i_cfg.par_en = 1'b1;
		cyc(1);
		ubf_node_i.send_frame(8'h01, 1'b0);
		cyc(1);
		chk(n_rxd - d, 3);
		chk(n_rxe - e, 1);
		chk(o_parity_err_flag, 1);
		chk({o_rx_valid, o_rx_word}, {1'b1, 8'h01, 2'b10});
		i_cfg.par_en = 1'b0;
		i_rx_ready = 1'b1;
		i_err_status_rd = 1'b1;
		cyc(1);
		i_rx_ready = 1'b0;
		i_err_status_rd = 1'b0;
		cyc(1);
		chk({o_rx_valid, o_parity_err_flag}, 0);
		$display("byte test done");
	endtask
	// Break reception either side of the width limit.
	task automatic t_brk_rx;
		int d;
		i_break_rx_set = 1'b1;
		cyc(1);
		i_break_rx_set = 1'b0;
		cyc(1);
		d = n_rxd;
		ubf_node_i.send_low(10);
		chk(n_rxd - d, 0);
		chk({o_break_rx_flag, o_break_rx_enable}, 2'b11);
		ubf_node_i.send_low(11);
		chk(n_rxd - d, 1);
		chk({o_break_rx_flag, o_break_rx_enable}, 0);
		chk({o_overrun_flag, o_parity_err_flag, o_framing_err_flag}, 0);
		chk(o_rx_valid, 0);
		$display("break receive test done");
	endtask
	// Main sequence.
	initial begin
		i_cfg.k = 8'h08;
		cyc(6);
		i_rst = 1'b0;
		cyc(1);
		t_clock();
		t_brk_tx();
		t_bytes();
		t_brk_rx();
		give_verdict();
	end
	// Bound on the whole run.
	initial begin
		repeat (60000) @(posedge i_clk);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire

// file: ubf_buf2.sv
// Two-entry buffer with valid/ready on both sides for received characters.
`timescale 1ns/100ps
`default_nettype none
module ubf_buf2 (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Filling side.
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire ubf_pkg::ubf_rx_word_t i_wr_word,
	// Draining side.
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output ubf_pkg::ubf_rx_word_t o_rd_word
);
	import ubf_pkg::*;

	typedef struct packed {
		ubf_rx_word_t [1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} ubf_buf_st_t;

	localparam logic [1:0] UBF_BUF_FULL = 2'h2;
	localparam logic [1:0] UBF_BUF_STEP = 2'h1;

	ubf_buf_st_t q, d;
	logic do_wr, do_rd;

	// Handshakes are combinational from the occupancy count.
	assign o_wr_ready = (q.count != UBF_BUF_FULL);
	assign o_rd_valid = (q.count != 2'h0);
	assign do_wr = i_wr_valid && o_wr_ready;
	assign do_rd = o_rd_valid && i_rd_ready;

	// Write at the tail, advance the head on a pop.
	always_comb begin
		d = q;
		if (do_wr) begin
			d.mem[q.wr_ptr] = i_wr_word;
			d.wr_ptr = ~q.wr_ptr;
		end
		if (do_rd) begin
			d.rd_ptr = ~q.rd_ptr;
		end
		if (do_wr && !do_rd) begin
			d.count = q.count + UBF_BUF_STEP;
		end else if (do_rd && !do_wr) begin
			d.count = q.count - UBF_BUF_STEP;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q <= '{'{UBF_RX_WORD_RST, UBF_RX_WORD_RST}, 1'b0, 1'b0, 2'h0};
		end else begin
			q <= d;
		end
	end

	// Head entry straight from the storage flops; all ones data and no error bits after reset.
	assign o_rd_word = q.mem[q.rd_ptr];
endmodule
`default_nettype wire

// file: ubf_core.sv
// Break field transmit/receive, noise filter, merge option and baud generator.
`timescale 1ns/100ps
`default_nettype none
module ubf_core (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Configuration bits.
	input wire ubf_pkg::ubf_cfg_t i_cfg,
	// Software control strobes.
	input wire logic i_break_tx_set,
	input wire logic i_break_rx_set,
	input wire logic i_err_status_rd,
	// Transmit buffer.
	input wire logic i_tx_wr,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_buf_full,
	output logic o_tx_busy,
	// Received character stream.
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	output ubf_pkg::ubf_rx_word_t o_rx_word,
	// Serial pins.
	input wire logic i_serial_rx_pin,
	output logic o_serial_tx_pin,
	// Status bits.
	output logic o_break_tx_trigger,
	output logic o_break_rx_enable,
	output logic o_break_rx_flag,
	output logic o_overrun_flag,
	output logic o_parity_err_flag,
	output logic o_framing_err_flag,
	// Interrupt pulses and base clock.
	output logic o_tx_done_irq,
	output logic o_rx_done_irq,
	output logic o_rx_err_irq,
	output logic o_base_clk
);
	import ubf_pkg::*;

	typedef struct packed {
		logic [UBF_PRE_W-1:0] pre;
		logic base_tick;
		ubf_tx_st_t tx_st;
		logic [7:0] tx_cnt;
		logic tx_half;
		logic [4:0] tx_bits;
		logic [9:0] tx_sh;
		logic tx_line;
		logic [7:0] txb;
		logic txb_full;
		logic brk_trig;
		logic tx_irq;
		ubf_rx_st_t rx_st;
		logic [7:0] rx_cnt;
		logic rx_half;
		logic [4:0] rx_bits;
		logic [8:0] rx_sh;
		logic rx_prev;
		logic brk_en;
		logic brk_flag;
		logic ove;
		logic pe;
		logic fe;
		logic rx_done;
		logic rx_err;
		logic push;
		ubf_rx_word_t push_word;
	} ubf_core_st_t;

	ubf_core_st_t q, d;
	logic rxf, buf_ready;
	logic [10:0] mask_w;
	logic [UBF_PRE_W-1:0] mask;
	logic sel_ok, tx_on, rx_on, tx_wrap, tx_bit, rx_wrap, rx_bit, tx_load;
	logic set_ove, set_pe, set_fe, brk_clr, frm_err;
	logic [7:0] k_last;
	logic [4:0] frame_bits;
	logic [7:0] rx_data;
	logic rx_par_bad;

	// Filtered receive level, two clocks plus three base clocks behind the pin.
	ubf_rx_filter u_filter (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_base_tick(q.base_tick),
		.i_pin(i_serial_rx_pin),
		.o_rx(rxf)
	);

	// Received characters wait here; a full buffer means overrun.
	ubf_buf2 u_rxbuf (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_wr_valid(q.push),
		.o_wr_ready(buf_ready),
		.i_wr_word(q.push_word),
		.o_rd_valid(o_rx_valid),
		.i_rd_ready(i_rx_ready),
		.o_rd_word(o_rx_word)
	);

	// Prescaler mask and per-direction counter wraps.
	assign mask_w = (UBF_ONE_11 << i_cfg.clk_sel) - UBF_ONE_11;
	assign mask = mask_w[UBF_PRE_W-1:0];
	assign sel_ok = (i_cfg.clk_sel <= UBF_SEL_MAX);
	assign tx_on = i_cfg.pwr && i_cfg.tx_en;
	assign rx_on = i_cfg.pwr && i_cfg.rx_en;
	assign k_last = i_cfg.k - UBF_K_ONE;
	assign tx_wrap = q.base_tick && (q.tx_cnt == k_last);
	assign tx_bit = tx_wrap && q.tx_half;
	assign rx_wrap = q.base_tick && (q.rx_cnt == k_last);
	assign rx_bit = rx_wrap && q.rx_half;
	assign frame_bits = UBF_DATA_BITS + {4'h0, i_cfg.par_en};
	assign rx_data = i_cfg.par_en ? q.rx_sh[7:0] : q.rx_sh[8:1];
	assign rx_par_bad = i_cfg.par_en && (^q.rx_sh);

	// Base clock, transmitter and receiver next state.
	always_comb begin
		d = q;
		d.base_tick = 1'b0;
		d.tx_irq = 1'b0;
		d.rx_done = 1'b0;
		d.rx_err = 1'b0;
		d.push = 1'b0;
		tx_load = 1'b0;
		set_ove = 1'b0;
		set_pe = 1'b0;
		set_fe = 1'b0;
		brk_clr = 1'b0;
		frm_err = 1'b0;
		d.rx_prev = rxf;

		// Base clock strobe exists only while power is on.
		if (!i_cfg.pwr) begin
			d.pre = '0;
		end else begin
			d.pre = q.pre + 1'b1;
			d.base_tick = sel_ok && ((q.pre & mask) == mask);
		end

		// Transmit side.
		if (!tx_on) begin
			d.tx_st = UBF_TX_IDLE;
			d.tx_cnt = '0;
			d.tx_half = 1'b0;
			d.tx_line = 1'b1;
			d.txb_full = 1'b0;
			d.brk_trig = 1'b0;
		end else begin
			if (q.base_tick) begin
				d.tx_cnt = tx_wrap ? 8'h00 : q.tx_cnt + UBF_K_ONE;
				d.tx_half = q.tx_half ^ tx_wrap;
			end
			if (i_tx_wr && !q.txb_full) begin
				d.txb = i_tx_data;
				d.txb_full = 1'b1;
			end
			case (q.tx_st)
				UBF_TX_IDLE: begin
					if (q.brk_trig) begin
						d.tx_st = UBF_TX_BRK;
						d.tx_bits = UBF_BRK_TX_BASE + {2'h0, i_cfg.brk_len};
						d.tx_line = 1'b0;
						d.tx_cnt = '0;
						d.tx_half = 1'b0;
					end else if (q.txb_full) begin
						tx_load = 1'b1;
					end
				end
				UBF_TX_FRAME: begin
					if (tx_bit) begin
						if (q.tx_bits == 5'h00) begin
							d.tx_irq = 1'b1;
							if (q.txb_full) begin
								tx_load = 1'b1;
							end else begin
								d.tx_st = UBF_TX_IDLE;
								d.tx_line = 1'b1;
							end
						end else begin
							d.tx_line = q.tx_sh[0];
							d.tx_sh = {1'b1, q.tx_sh[9:1]};
							d.tx_bits = q.tx_bits - UBF_STOP_BITS;
						end
					end
				end
				UBF_TX_BRK: begin
					if (tx_bit) begin
						if (q.tx_bits == UBF_BRK_TX_LAST) begin
							d.tx_st = UBF_TX_IDLE;
							d.tx_line = 1'b1;
							d.tx_irq = 1'b1;
							d.brk_trig = 1'b0;
						end else begin
							d.tx_bits = q.tx_bits - UBF_STOP_BITS;
						end
					end
				end
				default: begin
					d.tx_st = UBF_TX_IDLE;
				end
			endcase
			// A frame start clears the counter so the start bit is whole.
			if (tx_load) begin
				d.tx_st = UBF_TX_FRAME;
				d.tx_cnt = '0;
				d.tx_half = 1'b0;
				d.tx_line = 1'b0;
				d.tx_sh = {1'b1, i_cfg.par_en ? ^q.txb : 1'b1, q.txb};
				d.tx_bits = frame_bits + UBF_STOP_BITS;
				d.txb_full = 1'b0;
			end
			// A new trigger wins over the clear at break end.
			if (i_break_tx_set) begin
				d.brk_trig = 1'b1;
			end
		end

		// Receive side.
		if (!rx_on) begin
			d.rx_st = UBF_RX_IDLE;
			d.rx_cnt = '0;
			d.rx_half = 1'b0;
			d.brk_en = 1'b0;
			d.brk_flag = 1'b0;
		end else begin
			if (q.rx_st != UBF_RX_IDLE && q.base_tick) begin
				d.rx_cnt = rx_wrap ? 8'h00 : q.rx_cnt + UBF_K_ONE;
				d.rx_half = q.rx_half ^ rx_wrap;
			end
			case (q.rx_st)
				UBF_RX_IDLE: begin
					d.rx_cnt = '0;
					d.rx_half = 1'b0;
					if (q.rx_prev && !rxf) begin
						d.rx_st = UBF_RX_CHK;
					end
				end
				UBF_RX_CHK: begin
					if (rx_wrap) begin
						if (!rxf) begin
							d.rx_st = UBF_RX_DATA;
							d.rx_half = 1'b0;
							d.rx_bits = q.brk_en ? UBF_STOP_BITS : 5'h00;
							d.brk_flag = q.brk_en || q.brk_flag;
						end else begin
							d.rx_st = UBF_RX_IDLE;
						end
					end
				end
				UBF_RX_DATA: begin
					if (rx_bit) begin
						if (q.brk_en) begin
							if (!rxf) begin
								if (q.rx_bits != UBF_CNT_SAT) begin
									d.rx_bits = q.rx_bits + UBF_STOP_BITS;
								end
							end else begin
								d.rx_st = UBF_RX_IDLE;
								if (q.rx_bits >= UBF_BRK_RX_MIN) begin
									d.rx_done = 1'b1;
									d.brk_flag = 1'b0;
									brk_clr = 1'b1;
								end
							end
						end else if (q.rx_bits == frame_bits) begin
							d.rx_st = UBF_RX_IDLE;
							set_fe = !rxf;
							set_pe = rx_par_bad;
							set_ove = !buf_ready;
							frm_err = set_fe || set_pe || set_ove;
							d.push = buf_ready;
							d.push_word = '{rx_data, rx_par_bad, !rxf};
							if (i_cfg.merge || !frm_err) begin
								d.rx_done = 1'b1;
							end else begin
								d.rx_err = 1'b1;
							end
						end else begin
							d.rx_sh = {rxf, q.rx_sh[8:1]};
							d.rx_bits = q.rx_bits + UBF_STOP_BITS;
						end
					end
				end
				default: begin
					d.rx_st = UBF_RX_IDLE;
				end
			endcase
			// Enable bit: set strobe wins over the self clear.
			d.brk_en = (q.brk_en && !brk_clr) || i_break_rx_set;
		end

		// Error flags: a new error wins over the read clear.
		d.ove = (q.ove && !i_err_status_rd) || set_ove;
		d.pe = (q.pe && !i_err_status_rd) || set_pe;
		d.fe = (q.fe && !i_err_status_rd) || set_fe;
	end

	// Every field has a constant reset value.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q <= '0;
			q.tx_line <= 1'b1;
			q.rx_prev <= 1'b1;
			q.tx_sh <= '1;
			q.push_word <= UBF_RX_WORD_RST;
		end else begin
			q <= d;
		end
	end

	// The pin idles high with power on and stays low with power off.
	assign o_serial_tx_pin = i_cfg.pwr && q.tx_line;
	assign o_tx_buf_full = q.txb_full;
	assign o_tx_busy = (q.tx_st != UBF_TX_IDLE);
	assign o_break_tx_trigger = q.brk_trig;
	assign o_break_rx_enable = q.brk_en;
	assign o_break_rx_flag = q.brk_flag;
	assign o_overrun_flag = q.ove;
	assign o_parity_err_flag = q.pe;
	assign o_framing_err_flag = q.fe;
	assign o_tx_done_irq = q.tx_irq;
	assign o_rx_done_irq = q.rx_done;
	assign o_rx_err_irq = q.rx_err;
	assign o_base_clk = q.base_tick;
endmodule
`default_nettype wire

// file: ubf_core_monitor.sv
// Concurrent checks on the ports of the break field and baud unit.
`timescale 1ns/100ps
`default_nettype none
module ubf_core_monitor (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Inputs watched.
	input wire ubf_pkg::ubf_cfg_t i_cfg,
	input wire logic i_rx_ready,
	// Outputs watched.
	input wire logic o_serial_tx_pin,
	input wire logic o_base_clk,
	input wire logic o_tx_busy,
	input wire logic o_tx_buf_full,
	input wire logic o_break_tx_trigger,
	input wire logic o_break_rx_enable,
	input wire logic o_break_rx_flag,
	input wire logic o_framing_err_flag,
	input wire logic o_parity_err_flag,
	input wire logic o_overrun_flag,
	input wire logic o_rx_valid,
	input wire ubf_pkg::ubf_rx_word_t o_rx_word,
	input wire logic o_tx_done_irq,
	input wire logic o_rx_done_irq,
	input wire logic o_rx_err_irq
);
	import ubf_pkg::*;
	// All checks share the one clock and its reset.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	a_pin_off: assert property (!i_cfg.pwr |-> !o_serial_tx_pin)
		else $error("tx pin high while unpowered");
	a_pin_idle_high: assert property (i_cfg.pwr && !o_tx_busy
		&& !o_break_tx_trigger |-> o_serial_tx_pin)
		else $error("tx pin low while idle");
	a_base_clk_off: assert property ((!i_cfg.pwr)[*2] |-> !o_base_clk)
		else $error("base clock runs unpowered");
	a_base_sel_rsvd: assert property ((i_cfg.clk_sel > UBF_SEL_MAX)[*2]
		|-> !o_base_clk)
		else $error("base clock runs on reserved select");
	a_brk_tx_start: assert property ($rose(o_break_tx_trigger)
		|-> ##[1:2] !o_serial_tx_pin)
		else $error("break did not pull tx low");
	a_brk_tx_end: assert property ($fell(o_break_tx_trigger) && i_cfg.pwr
		&& i_cfg.tx_en |-> (o_tx_done_irq || $past(o_tx_done_irq))
		or (##1 o_tx_done_irq))
		else $error("break end without tx done");
	a_brk_tx_idle: assert property ($fell(o_break_tx_trigger) && i_cfg.pwr
		&& i_cfg.tx_en && !o_tx_buf_full |=> !o_tx_busy)
		else $error("transmitter busy after break");
	a_irq_merge: assert property (o_rx_err_irq |-> !i_cfg.merge)
		else $error("error irq while merged");
	a_irq_excl: assert property (!(o_rx_err_irq && o_rx_done_irq))
		else $error("done and error irq together");
	a_brk_rx_clear: assert property (o_rx_done_irq
		&& $past(o_break_rx_flag) |=> !o_break_rx_flag && !o_break_rx_enable)
		else $error("break flags not cleared");
	a_brk_no_err: assert property (o_break_rx_flag |->
		!$rose(o_framing_err_flag) && !$rose(o_parity_err_flag)
		&& !$rose(o_overrun_flag))
		else $error("error flag set in break mode");
	a_rx_stall_hold: assert property (o_rx_valid && !i_rx_ready
		|=> o_rx_valid && $stable(o_rx_word))
		else $error("stalled word lost or changed");
	// Main scenarios reached.
	c_brk_rx_done: cover property ($fell(o_break_rx_enable));
	c_rx_err: cover property (o_rx_err_irq);
	c_brk_tx_done: cover property ($fell(o_break_tx_trigger));
endmodule
bind ubf_core ubf_core_monitor ubf_core_monitor_i (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_cfg(i_cfg),
	.i_rx_ready(i_rx_ready),
	.o_serial_tx_pin(o_serial_tx_pin),
	.o_base_clk(o_base_clk),
	.o_tx_busy(o_tx_busy),
	.o_tx_buf_full(o_tx_buf_full),
	.o_break_tx_trigger(o_break_tx_trigger),
	.o_break_rx_enable(o_break_rx_enable),
	.o_break_rx_flag(o_break_rx_flag),
	.o_framing_err_flag(o_framing_err_flag),
	.o_parity_err_flag(o_parity_err_flag),
	.o_overrun_flag(o_overrun_flag),
	.o_rx_valid(o_rx_valid),
	.o_rx_word(o_rx_word),
	.o_tx_done_irq(o_tx_done_irq),
	.o_rx_done_irq(o_rx_done_irq),
	.o_rx_err_irq(o_rx_err_irq)
);
`default_nettype wire

// file: ubf_node.sv
// Remote serial node driving the receive pin and decoding the tx pin.
`timescale 1ns/100ps
`default_nettype none
module ubf_node #(
	parameter int BIT = 16
) (
	// Clock and lines.
	input wire logic i_clk,
	input wire logic i_tx_line,
	output logic o_line
);
	// Line idles high; levels change on the falling clock edge.
	initial o_line = 1'b1;
	task automatic hold(input logic v, input int n);
		o_line = v;
		repeat (n) @(negedge i_clk);
	endtask
	// Frame is start, eight data bits LSB first and one stop bit.
	task automatic send_frame(input logic [7:0] d, input logic stp);
		hold(1'b0, BIT);
		for (int i = 0; i < 8; i++)
			hold(d[i], BIT);
		hold(stp, BIT);
		hold(1'b1, 40);
	endtask
	// Break is a low stretch of whole bit times.
	task automatic send_low(input int n);
		hold(1'b0, n * BIT);
		hold(1'b1, 48);
	endtask
	// Samples each bit in its middle.
	task automatic get_frame(output logic [7:0] d, output logic ok);
		int w;
		w = 0;
		while (i_tx_line && w < 400) begin
			@(negedge i_clk);
			w++;
		end
		repeat (BIT / 2) @(negedge i_clk);
		ok = !i_tx_line;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(negedge i_clk);
			d[i] = i_tx_line;
		end
		repeat (BIT) @(negedge i_clk);
		ok = ok && i_tx_line;
	endtask
endmodule
`default_nettype wire

// file: ubf_pkg.sv
// Shared constants, state encodings and carrier types for the break/baud unit.
`default_nettype none
package ubf_pkg;
	// Prescaler width and largest legal base clock select value.
	localparam int unsigned UBF_PRE_W = 10;
	localparam logic [3:0] UBF_SEL_MAX = 4'hA;
	localparam logic [10:0] UBF_ONE_11 = 11'h001;
	// Frame shape.
	localparam logic [4:0] UBF_DATA_BITS = 5'h08;
	localparam logic [4:0] UBF_STOP_BITS = 5'h01;
	// Break field lengths in bit times, and the baud counter step.
	localparam logic [4:0] UBF_BRK_TX_BASE = 5'h0D;
	localparam logic [4:0] UBF_BRK_RX_MIN = 5'h0B;
	localparam logic [4:0] UBF_BRK_TX_LAST = 5'h01;
	localparam logic [4:0] UBF_CNT_SAT = 5'h1F;
	localparam logic [7:0] UBF_K_ONE = 8'h01;
	// Receive buffer reset value: all ones data, no error bits.
	localparam logic [7:0] UBF_RXB_RST = 8'hFF;

	// Static configuration bits as software holds them.
	typedef struct packed {
		logic pwr;
		logic tx_en;
		logic rx_en;
		logic merge;
		logic par_en;
		logic [2:0] brk_len;
		logic [3:0] clk_sel;
		logic [7:0] k;
	} ubf_cfg_t;

	// One received character as it travels through the buffer.
	typedef struct packed {
		logic [7:0] data;
		logic pe;
		logic fe;
	} ubf_rx_word_t;

	localparam ubf_rx_word_t UBF_RX_WORD_RST = '{UBF_RXB_RST, 1'b0, 1'b0};

	typedef enum logic [1:0] {
		UBF_TX_IDLE = 2'h0,
		UBF_TX_FRAME = 2'h1,
		UBF_TX_BRK = 2'h3
	} ubf_tx_st_t;

	typedef enum logic [1:0] {
		UBF_RX_IDLE = 2'h0,
		UBF_RX_CHK = 2'h1,
		UBF_RX_DATA = 2'h3
	} ubf_rx_st_t;
endpackage
`default_nettype wire

// file: ubf_rx_filter.sv
// Receive pin synchroniser and two-sample agreement noise filter.
`timescale 1ns/100ps
`default_nettype none
module ubf_rx_filter (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Base clock sample strobe.
	input wire logic i_base_tick,
	// Raw pin and filtered level.
	input wire logic i_pin,
	output logic o_rx
);
	import ubf_pkg::*;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic smp0;
		logic smp1;
		logic out;
	} ubf_flt_st_t;

	ubf_flt_st_t q, d;

	// The output follows only when the two latest base clock samples agree.
	always_comb begin
		d = q;
		d.sync1 = i_pin;
		d.sync2 = q.sync1;
		if (i_base_tick) begin
			d.smp0 = q.sync2;
			d.smp1 = q.smp0;
			if (q.smp0 == q.smp1) begin
				d.out = q.smp0;
			end
		end
	end

	// Idle line is high, so every stage resets high.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign o_rx = q.out;
endmodule
`default_nettype wire
